// file: verilog/pwl_lock.sv
// Write lock, slave addressing and channel option bits of the bus command port
`timescale 1ns/1ps
module pwl_lock import pwl_pkg::*; #(
	parameter logic [7:0] CMD_NVM_UNLOCK = 8'hC0,
	parameter logic [7:0] CMD_PEAK_CLR = 8'hC1,
	parameter int MIN_CYC = MIN_OFF_CYC,
	parameter int DLY_CYC = 100,
	parameter int FALL_CYC = 100,
	parameter int MAXW_CYC = 1000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_data,
	output logic wr_done_r,
	output logic wr_refused_r,
	output logic rd_valid_r,
	output logic [7:0] rd_data_r,
	input wire logic [6:0] bus_addr,
	output logic addr_hit,
	output logic global_hit,
	output logic rail_hit,
	input wire logic rail_rd_clash,
	input wire logic wp_pin,
	input wire logic [3:0] asel_lo_val,
	input wire logic asel_lo_open,
	input wire logic [2:0] asel_hi_val,
	input wire logic asel_hi_open,
	input wire logic calc_busy,
	input wire logic chip_busy,
	input wire logic share_clk_in,
	input wire logic [1:0] fault_pin_in,
	input wire logic [1:0] run_pin_in,
	input wire logic [1:0] vout_low_in,
	input wire logic [1:0] fault_trip,
	output logic [1:0] pwm_en,
	output logic [1:0] run_o,
	output logic [1:0] run_oe,
	output logic alert_o,
	output logic alert_oe,
	output logic [1:0] toff_warn,
	output logic comm_fault_r
);
	localparam int SW = 17;

	logic [SW-1:0] sy1_r;
	logic [SW-1:0] sy2_r;
	logic wp_s;
	logic [3:0] lo_s;
	logic lo_open_s;
	logic [2:0] hi_s;
	logic hi_open_s;
	logic share_s;
	logic [1:0] fault_s;
	logic [1:0] run_s;
	logic [1:0] vlow_s;
	logic [1:0] run_prev_r;
	logic [7:0] page_r;
	logic [7:0] lvl_r;
	logic [7:0] addr_r;
	logic [7:0] glb_r;
	logic [7:0] opt_r [2];
	logic [7:0] rail_r [2];
	logic [1:0] ch_sel;
	logic pidx;
	logic ok;
	logic wr_acc;
	logic [6:0] eff_addr;
	logic [1:0] trans;
	logic [1:0] on_req;
	logic [1:0] off_req;
	logic [1:0] hard_off;
	logic [1:0] run_low;
	logic [1:0] alert_req;
	logic [7:0] common;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_r <= '0;
			sy2_r <= '0;
		end else begin
			sy1_r <= {wp_pin, asel_lo_val, asel_lo_open, asel_hi_val, asel_hi_open,
				share_clk_in, fault_pin_in, run_pin_in, vout_low_in};
			sy2_r <= sy1_r;
		end
	end

	assign {wp_s, lo_s, lo_open_s, hi_s, hi_open_s, share_s, fault_s, run_s, vlow_s} = sy2_r;

	// ==========================================
	// Lock decode
	function automatic logic lock_ok(input logic [7:0] c, input logic [7:0] lvl,
		input logic wp);
		logic st;
		logic a;
		logic b;
		logic d;
		st = c >= CMD_ST_FIRST && c <= CMD_ST_LAST;
		a = c == CMD_WP || c == CMD_PAGE || c == CMD_NVM_UNLOCK || c == CMD_STORE;
		b = a || c == CMD_PEAK_CLR || c == CMD_OPER || c == CMD_CLR;
		d = b || c == CMD_ONOFF || c == CMD_VOUT;
		if (wp)
			lock_ok = st || c == CMD_PAGE || c == CMD_OPER || c == CMD_PEAK_CLR ||
				c == CMD_NVM_UNLOCK || c == CMD_WP || c == CMD_CLR;
		else if (lvl[LCK_ALL])
			lock_ok = a || st;
		else if (lvl[LCK_CTRL])
			lock_ok = b || st;
		else if (lvl[LCK_CFG])
			lock_ok = d || st;
		else
			lock_ok = 1'b1;
	endfunction

	assign ok = lock_ok(cmd_code, lvl_r, wp_s);
	assign wr_acc = cmd_wr && ok;
	assign pidx = page_r[0];
	assign ch_sel = (page_r == PAGE_ALL) ? 2'b11 : (pidx ? 2'b10 : 2'b01);

	// ==========================================
	// Write answer and fault flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_done_r <= 1'b0;
			wr_refused_r <= 1'b0;
		end else begin
			wr_done_r <= wr_acc;
			wr_refused_r <= cmd_wr && !ok;
		end
	end

	// Setting wins over a clear arriving in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			comm_fault_r <= 1'b0;
		else if ((cmd_wr && !ok) || rail_rd_clash)
			comm_fault_r <= 1'b1;
		else if (wr_acc && cmd_code == CMD_CLR)
			comm_fault_r <= 1'b0;
	end

	// ==========================================
	// Registers; refused writes never reach them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page_r <= RST_PAGE;
			lvl_r <= RST_WP;
			addr_r <= RST_ADDR;
			glb_r <= RST_GLB_OPT;
		end else if (wr_acc) begin
			if (cmd_code == CMD_PAGE)
				page_r <= cmd_data;
			if (cmd_code == CMD_WP)
				lvl_r <= cmd_data;
			if (cmd_code == CMD_ADDR)
				addr_r <= cmd_data;
			if (cmd_code == CMD_GLB_OPT)
				glb_r <= cmd_data;
		end
	end

	generate
		for (genvar i = 0; i < 2; i++) begin : g_paged
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					opt_r[i] <= RST_CHAN_OPT;
					rail_r[i] <= RST_RAIL;
				end else if (wr_acc && ch_sel[i]) begin
					if (cmd_code == CMD_CHAN_OPT)
						opt_r[i] <= cmd_data;
					if (cmd_code == CMD_RAIL)
						rail_r[i] <= cmd_data;
				end
			end

			assign on_req[i] = wr_acc && ch_sel[i] && cmd_code == CMD_OPER &&
				cmd_data == OPER_ON;
			assign off_req[i] = wr_acc && ch_sel[i] && cmd_code == CMD_OPER &&
				(cmd_data == OPER_SOFT || cmd_data == OPER_IMM);
			assign hard_off[i] = fault_trip[i] || (run_prev_r[i] && !run_s[i]);
			// Outside fault pull-down raises no alert when masked
			assign alert_req[i] = !fault_s[i] && !opt_r[i][OPT_NO_ALERT];

			pwl_chan #(
				.MIN_CYC(MIN_CYC),
				.DLY_CYC(DLY_CYC),
				.FALL_CYC(FALL_CYC),
				.MAXW_CYC(MAXW_CYC)
			) u_chan (
				.clk(clk),
				.rst_n(rst_n),
				.on_req(on_req[i]),
				.off_req(off_req[i]),
				.hard_off(hard_off[i]),
				.opt(opt_r[i][4:0]),
				.sync_low(!share_s),
				.vout_low(vlow_s[i]),
				.pwm_en(pwm_en[i]),
				.run_low_r(run_low[i]),
				.in_trans(trans[i]),
				.warn_r(toff_warn[i])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			run_prev_r <= 2'b00;
		else
			run_prev_r <= run_s;
	end

	// Open drain outputs only ever pull low
	assign run_o = 2'b00;
	assign run_oe = run_low;
	assign alert_o = 1'b0;
	assign alert_oe = |alert_req;

	// ==========================================
	// Addressing
	// Pin selections win even when the resistor option says ignore
	assign eff_addr = {hi_open_s ? addr_r[6:4] : hi_s,
		lo_open_s ? addr_r[3:0] : lo_s};
	assign addr_hit = addr_r != ADDR_OFF && bus_addr == eff_addr;
	assign global_hit = bus_addr == GLOBAL_A || bus_addr == GLOBAL_B;
	assign rail_hit = rail_r[pidx] != ADDR_OFF && bus_addr == rail_r[pidx][6:0];

	// ==========================================
	// Reads
	always_comb begin
		common = 8'h00;
		common[CB_NOT_BUSY] = !chip_busy;
		common[CB_NO_CALC] = !calc_busy;
		common[CB_NO_TRANS] = !(|trans);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= 8'h00;
		end else begin
			rd_valid_r <= cmd_rd;
			if (cmd_rd) begin
				unique case (cmd_code)
					CMD_PAGE: rd_data_r <= page_r;
					CMD_WP: rd_data_r <= lvl_r;
					CMD_ADDR: rd_data_r <= addr_r;
					CMD_GLB_OPT: rd_data_r <= glb_r;
					CMD_CHAN_OPT: rd_data_r <= opt_r[pidx];
					CMD_RAIL: rd_data_r <= rail_r[pidx];
					CMD_COMMON: rd_data_r <= common;
					default: rd_data_r <= RD_NONE;
				endcase
			end
		end
	end

	// ==========================================
	// Checks
	a_pin_lock: assert property (@(posedge clk) disable iff (!rst_n)
		wp_s && cmd_wr && cmd_code == CMD_STORE |=> wr_refused_r && !wr_done_r)
		else $error("store accepted under lock pin");
	a_pin_over: assert property (@(posedge clk) disable iff (!rst_n)
		wp_s && lvl_r == 8'h00 && cmd_wr && cmd_code == CMD_ONOFF |=> wr_refused_r)
		else $error("lock pin did not override");
	a_lvl_all: assert property (@(posedge clk) disable iff (!rst_n)
		!wp_s && lvl_r == 8'h80 && cmd_wr && cmd_code == CMD_OPER |=> wr_refused_r)
		else $error("operation accepted at 0x80");
	a_lvl_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
		!wp_s && lvl_r == 8'h40 && cmd_wr && cmd_code == CMD_ONOFF |=> wr_refused_r)
		else $error("config accepted at 0x40");
	a_lvl_cfg: assert property (@(posedge clk) disable iff (!rst_n)
		!wp_s && lvl_r == 8'h20 && cmd_wr && cmd_code == CMD_VOUT |=> wr_done_r)
		else $error("setpoint refused at 0x20");
	a_status_clr: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr && cmd_code >= CMD_ST_FIRST && cmd_code <= CMD_ST_LAST |=> wr_done_r)
		else $error("status clear refused");
	a_lvl_open: assert property (@(posedge clk) disable iff (!rst_n)
		!wp_s && lvl_r == 8'h00 && cmd_wr |=> wr_done_r && !wr_refused_r)
		else $error("write refused when unlocked");
	a_refuse_keep: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr && !ok |=> $stable(addr_r) && $stable(glb_r) && $stable(opt_r[0]) &&
		$stable(opt_r[1]) && comm_fault_r)
		else $error("refused write changed state");
	a_addr_off: assert property (@(posedge clk) disable iff (!rst_n)
		addr_r == ADDR_OFF |-> !addr_hit) else $error("hit with address disabled");
	a_global_on: assert property (@(posedge clk) disable iff (!rst_n)
		bus_addr == 7'h5B |-> global_hit) else $error("global address missed");
	a_addr_open: assert property (@(posedge clk) disable iff (!rst_n)
		lo_open_s && hi_open_s |-> eff_addr == addr_r[6:0])
		else $error("stored address not used");
	a_rail_off: assert property (@(posedge clk) disable iff (!rst_n)
		rail_r[pidx] == 8'h80 |-> !rail_hit) else $error("rail hit while disabled");
	a_common_tr: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_rd && cmd_code == CMD_COMMON && |trans |=> rd_valid_r && !rd_data_r[4])
		else $error("transition bit not cleared");

	c_refused: cover property (@(posedge clk) disable iff (!rst_n) wr_refused_r);
	c_rail: cover property (@(posedge clk) disable iff (!rst_n) rail_hit && cmd_wr);
	c_warn: cover property (@(posedge clk) disable iff (!rst_n) |toff_warn);
endmodule // pwl_lock

// file: pkg/pwl_pkg.sv
// Command codes, field positions, reset values and timing for the write-lock block
package pwl_pkg;
	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_OPER = 8'h01;
	localparam logic [7:0] CMD_ONOFF = 8'h02;
	localparam logic [7:0] CMD_CLR = 8'h03;
	localparam logic [7:0] CMD_WP = 8'h10;
	localparam logic [7:0] CMD_STORE = 8'h15;
	localparam logic [7:0] CMD_VOUT = 8'h21;
	localparam logic [7:0] CMD_ST_FIRST = 8'h78;
	localparam logic [7:0] CMD_ST_LAST = 8'h80;
	localparam logic [7:0] CMD_CHAN_OPT = 8'hD0;
	localparam logic [7:0] CMD_GLB_OPT = 8'hD1;
	localparam logic [7:0] CMD_ADDR = 8'hE6;
	localparam logic [7:0] CMD_COMMON = 8'hEF;
	localparam logic [7:0] CMD_RAIL = 8'hFA;
	// ==========================================
	// Reset values
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_WP = 8'h00;
	localparam logic [7:0] RST_ADDR = 8'h4F;
	localparam logic [7:0] RST_RAIL = 8'h80;
	localparam logic [7:0] RST_CHAN_OPT = 8'h1D;
	localparam logic [7:0] RST_GLB_OPT = 8'h21;
	// ==========================================
	// Fields and values
	localparam int LCK_ALL = 7;
	localparam int LCK_CTRL = 6;
	localparam int LCK_CFG = 5;
	localparam int OPT_NO_RUN_LOW = 4;
	localparam int OPT_SHORT_CYC = 3;
	localparam int OPT_SYNC_GATE = 2;
	localparam int OPT_NO_ALERT = 1;
	localparam int OPT_NO_DECAY = 0;
	localparam int CB_NOT_BUSY = 6;
	localparam int CB_NO_CALC = 5;
	localparam int CB_NO_TRANS = 4;
	localparam logic [7:0] ADDR_OFF = 8'h80;
	localparam logic [7:0] PAGE_ALL = 8'hFF;
	localparam logic [7:0] OPER_ON = 8'h80;
	localparam logic [7:0] OPER_SOFT = 8'h40;
	localparam logic [7:0] OPER_IMM = 8'h00;
	localparam logic [6:0] GLOBAL_A = 7'h5A;
	localparam logic [6:0] GLOBAL_B = 7'h5B;
	localparam logic [7:0] RD_NONE = 8'hFF;
	// ==========================================
	// Timing
	localparam int CLK_KHZ = 100000;
	localparam int MIN_OFF_MS = 120;
	localparam int MIN_OFF_CYC = MIN_OFF_MS * CLK_KHZ;
endpackage

// file: verilog/pwl_chan.sv
// One output channel: off sequencing, short cycle, decay wait and gating
`timescale 1ns/1ps
module pwl_chan import pwl_pkg::*; #(
	parameter int CW = 24,
	parameter int MIN_CYC = MIN_OFF_CYC,
	parameter int DLY_CYC = 100,
	parameter int FALL_CYC = 100,
	parameter int MAXW_CYC = 1000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic on_req,
	input wire logic off_req,
	input wire logic hard_off,
	input wire logic [4:0] opt,
	input wire logic sync_low,
	input wire logic vout_low,
	output logic pwm_en,
	output logic run_low_r,
	output logic in_trans,
	output logic warn_r
);
	typedef enum logic [2:0] {ST_OFF, ST_ON, ST_DLY, ST_FALL, ST_MIN, ST_DECAY} pwl_st_t;
	pwl_st_t st_r;
	logic [CW-1:0] cnt_r;
	logic decayed;
	logic hit;

	assign decayed = opt[OPT_NO_DECAY] | vout_low;
	assign hit = (st_r == ST_DLY && cnt_r >= CW'(DLY_CYC - 1)) ||
		(st_r == ST_FALL && cnt_r >= CW'(FALL_CYC - 1)) ||
		(st_r == ST_MIN && cnt_r >= CW'(MIN_CYC - 1));

	// ==========================================
	// Sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_OFF;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + CW'(1);
			unique case (st_r)
				ST_OFF: if (on_req) begin
					st_r <= decayed ? ST_ON : ST_DECAY;
					cnt_r <= '0;
				end
				ST_ON: if (hard_off) begin
					st_r <= ST_DECAY;
					cnt_r <= '0;
				end else if (off_req) begin
					st_r <= ST_DLY;
					cnt_r <= '0;
				end
				ST_DLY, ST_FALL: if (hard_off) begin
					st_r <= ST_OFF;
				end else if (on_req && opt[OPT_SHORT_CYC]) begin
					st_r <= ST_MIN;
					cnt_r <= '0;
				end else if (hit) begin
					st_r <= (st_r == ST_DLY) ? ST_FALL : ST_OFF;
					cnt_r <= '0;
				end
				ST_MIN: if (hit) begin
					st_r <= decayed ? ST_ON : ST_DECAY;
					cnt_r <= '0;
				end
				ST_DECAY: begin
					if (decayed)
						st_r <= ST_ON;
					if (cnt_r == CW'(MAXW_CYC))
						cnt_r <= cnt_r;
				end
			endcase
		end
	end

	// Warning only exists while the decay wait is enforced
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			warn_r <= 1'b0;
		else if (st_r != ST_DECAY || opt[OPT_NO_DECAY])
			warn_r <= 1'b0;
		else if (cnt_r == CW'(MAXW_CYC))
			warn_r <= 1'b1;
	end

	// Run pin pulse on a commanded off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			run_low_r <= 1'b0;
		else
			run_low_r <= st_r == ST_ON && off_req && !hard_off && !opt[OPT_NO_RUN_LOW];
	end

	assign pwm_en = (st_r == ST_ON || st_r == ST_DLY || st_r == ST_FALL) &&
		!(opt[OPT_SYNC_GATE] && sync_low);
	assign in_trans = st_r != ST_ON && st_r != ST_OFF;

	// ==========================================
	// Checks
	a_sync_gate: assert property (@(posedge clk) disable iff (!rst_n)
		opt[OPT_SYNC_GATE] && sync_low |-> !pwm_en) else $error("output on while sync low");
	a_run_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		opt[OPT_NO_RUN_LOW] |=> !run_low_r) else $error("run pulsed while disabled");
	a_decay_hold: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == ST_DECAY && !decayed |=> st_r == ST_DECAY && !pwm_en)
		else $error("restart before decay");
	a_short_cyc: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == ST_DLY && on_req && opt[OPT_SHORT_CYC] && !hard_off |=> st_r == ST_MIN && !pwm_en)
		else $error("short cycle not taken");
	c_short_cyc: cover property (@(posedge clk) disable iff (!rst_n)
		st_r == ST_MIN ##1 st_r == ST_ON);
endmodule // pwl_chan

// file: sim/pwl_env.sv
// Output voltage model seen by the channel decay comparators
`timescale 1ns/1ps
module pwl_env #(
	parameter int DECAY = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] pwm_en,
	output logic [1:0] vout_low_in
);
	// ==========================================
	// Decay counters
	// Output stays high for a while after switching stops, so restart gating shows
	int cnt [2];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '{0, 0};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pwm_en[i])
					cnt[i] <= 0;
				else if (cnt[i] < DECAY)
					cnt[i] <= cnt[i] + 1;
			end
		end
	end
	assign vout_low_in[0] = (cnt[0] >= DECAY);
	assign vout_low_in[1] = (cnt[1] >= DECAY);
endmodule // pwl_env

// file: sim/pwl_lock_test.sv
// Self-checking bench for the write lock, addressing and channel options
`timescale 1ns/1ps
module pwl_lock_test;
	import pwl_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
	logic [7:0] cmd_code = 8'h00, cmd_data = 8'h00;
	logic [6:0] bus_addr = 7'h00;
	logic rail_rd_clash = 1'b0, wp_pin = 1'b0, calc_busy = 1'b0, chip_busy = 1'b0;
	logic [3:0] asel_lo_val = 4'h0;
	logic [2:0] asel_hi_val = 3'h0;
	logic asel_lo_open = 1'b1, asel_hi_open = 1'b1, share_clk_in = 1'b1;
	logic [1:0] fault_pin_in = 2'h3, run_pin_in = 2'h3, fault_trip = 2'h0;
	logic wr_done_r, wr_refused_r, rd_valid_r, addr_hit, global_hit, rail_hit;
	logic alert_o, alert_oe, comm_fault_r;
	logic [7:0] rd_data_r;
	logic [1:0] pwm_en, run_o, run_oe, toff_warn, vout_low_in;
	int err_total = 0, checks_done = 0, cycles = 0, runs = 0, r0;
	logic [7:0] codes [11] = '{CMD_WP, CMD_PAGE, 8'hC0, CMD_STORE, 8'hC1, CMD_OPER,
		CMD_CLR, CMD_ONOFF, CMD_VOUT, CMD_GLB_OPT, CMD_ST_FIRST};
	logic [7:0] dats [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, OPER_SOFT,
		8'h00, 8'h1E, 8'h00, RST_GLB_OPT, 8'h01};
	logic [7:0] lvls [5] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00};
	logic [10:0] masks [5] = '{11'h40F, 11'h47F, 11'h5FF, 11'h7FF, 11'h477};

	always #5 clk = ~clk;

	pwl_lock #(.MIN_CYC(50), .DLY_CYC(5), .FALL_CYC(5), .MAXW_CYC(8)) i_dut (
		.clk, .rst_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_data, .wr_done_r,
		.wr_refused_r, .rd_valid_r, .rd_data_r, .bus_addr, .addr_hit, .global_hit,
		.rail_hit, .rail_rd_clash, .wp_pin, .asel_lo_val, .asel_lo_open,
		.asel_hi_val, .asel_hi_open, .calc_busy, .chip_busy, .share_clk_in,
		.fault_pin_in, .run_pin_in, .vout_low_in, .fault_trip, .pwm_en, .run_o,
		.run_oe, .alert_o, .alert_oe, .toff_warn, .comm_fault_r);

	pwl_env #(.DECAY(10)) i_env (.clk, .rst_n, .pwm_en, .vout_low_in);

	// ==========================================
	// Pulse counter and hang guard
	always @(posedge clk) begin
		if (run_oe[0] === 1'b1)
			runs++;
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			give_verdict();
		end
	end

	// ==========================================
	// Tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Write: taken at one edge, answer stands for the following cycle
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic ok);
		@(posedge clk);
		cmd_wr <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		@(posedge clk);
		cmd_wr <= 1'b0;
		#1;
		chk({6'h00, wr_done_r, wr_refused_r}, {6'h00, ok, !ok}, "write answer");
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		@(posedge clk);
		cmd_rd <= 1'b1;
		cmd_code <= c;
		@(posedge clk);
		cmd_rd <= 1'b0;
		#1;
		chk({7'h00, rd_valid_r}, 8'h01, "read valid");
		chk(rd_data_r, e, "read data");
	endtask

	// Hits compared as {individual, global, rail}
	task automatic adr(input logic [6:0] a, input logic [2:0] e);
		@(posedge clk);
		bus_addr <= a;
		@(posedge clk);
		#1;
		chk({5'h00, addr_hit, global_hit, rail_hit}, {5'h00, e}, "address hits");
	endtask

	task automatic pins(input logic lo, input logic [3:0] lv, input logic hi,
		input logic [2:0] hv);
		@(posedge clk);
		asel_lo_open <= lo;
		asel_lo_val <= lv;
		asel_hi_open <= hi;
		asel_hi_val <= hv;
		cyc(4);
	endtask

	task automatic wpwm(input logic v, input int n);
		int k = 0;
		while (pwm_en[0] !== v && k < n) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({7'h00, pwm_en[0]}, {7'h00, v}, "channel enable");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		cyc(3);
		rd(CMD_CHAN_OPT, RST_CHAN_OPT);
		rd(CMD_GLB_OPT, RST_GLB_OPT);
		rd(CMD_ADDR, RST_ADDR);
		rd(CMD_RAIL, RST_RAIL);
		rd(CMD_WP, RST_WP);
		$display("test reset values done");
		// Last pass raises the lock pin over a fully open level
		for (int l = 0; l < 5; l++) begin
			if (l == 4) begin
				wp_pin <= 1'b1;
				cyc(4);
			end
			wr(CMD_WP, lvls[l], 1'b1);
			for (int i = 1; i < 11; i++)
				wr(codes[i], dats[i], masks[l][i]);
		end
		wr(CMD_GLB_OPT, 8'h55, 1'b0);
		cyc(1);
		chk({7'h00, comm_fault_r}, 8'h01, "fault flag");
		rd(CMD_GLB_OPT, RST_GLB_OPT);
		wr(CMD_CLR, 8'h00, 1'b1);
		cyc(1);
		chk({7'h00, comm_fault_r}, 8'h00, "fault flag");
		wp_pin <= 1'b0;
		cyc(4);
		$display("test lock levels done");
		adr(7'h4F, 3'b100);
		adr(7'h4E, 3'b000);
		adr(7'h5A, 3'b010);
		adr(7'h5B, 3'b010);
		pins(1'b1, 4'h0, 1'b0, 3'h2);
		adr(7'h2F, 3'b100);
		pins(1'b0, 4'h3, 1'b1, 3'h0);
		adr(7'h43, 3'b100);
		wr(CMD_GLB_OPT, 8'h61, 1'b1);
		pins(1'b0, 4'h5, 1'b0, 3'h1);
		adr(7'h15, 3'b100);
		pins(1'b1, 4'h0, 1'b1, 3'h0);
		wr(CMD_ADDR, 8'h33, 1'b1);
		adr(7'h33, 3'b100);
		wr(CMD_ADDR, ADDR_OFF, 1'b1);
		adr(7'h00, 3'b000);
		adr(7'h5A, 3'b010);
		wr(CMD_RAIL, 8'h30, 1'b1);
		adr(7'h30, 3'b001);
		wr(CMD_RAIL, ADDR_OFF, 1'b1);
		adr(7'h30, 3'b000);
		@(posedge clk);
		rail_rd_clash <= 1'b1;
		@(posedge clk);
		rail_rd_clash <= 1'b0;
		cyc(2);
		chk({7'h00, comm_fault_r}, 8'h01, "clash flag");
		rd(CMD_COMMON, 8'h70);
		calc_busy <= 1'b1;
		rd(CMD_COMMON, 8'h50);
		calc_busy <= 1'b0;
		chip_busy <= 1'b1;
		rd(CMD_COMMON, 8'h30);
		chip_busy <= 1'b0;
		$display("test addressing done");
		wr(CMD_OPER, OPER_ON, 1'b1);
		wpwm(1'b1, 5);
		@(posedge clk);
		share_clk_in <= 1'b0;
		wpwm(1'b0, 5);
		share_clk_in <= 1'b1;
		wpwm(1'b1, 5);
		r0 = runs;
		wr(CMD_OPER, OPER_SOFT, 1'b1);
		rd(CMD_COMMON, 8'h60);
		wpwm(1'b0, 15);
		chk(8'(runs - r0), 8'h00, "run pulses");
		wr(CMD_OPER, OPER_ON, 1'b1);
		wpwm(1'b1, 5);
		wr(CMD_OPER, OPER_SOFT, 1'b1);
		wr(CMD_OPER, OPER_ON, 1'b1);
		wpwm(1'b0, 3);
		cyc(35);
		chk({7'h00, pwm_en[0]}, 8'h00, "minimum off");
		wpwm(1'b1, 25);
		wr(CMD_CHAN_OPT, 8'h0C, 1'b1);
		r0 = runs;
		@(posedge clk);
		fault_trip <= 2'h1;
		@(posedge clk);
		fault_trip <= 2'h0;
		wr(CMD_OPER, OPER_ON, 1'b1);
		cyc(2);
		chk({7'h00, pwm_en[0]}, 8'h00, "decay wait");
		cyc(6);
		chk({6'h00, toff_warn}, 8'h01, "off warning");
		wpwm(1'b1, 30);
		wr(CMD_CHAN_OPT, 8'h0D, 1'b1);
		@(posedge clk);
		fault_trip <= 2'h1;
		@(posedge clk);
		fault_trip <= 2'h0;
		wr(CMD_OPER, OPER_ON, 1'b1);
		wpwm(1'b1, 4);
		chk({6'h00, toff_warn}, 8'h00, "off warning");
		wr(CMD_OPER, OPER_SOFT, 1'b1);
		cyc(15);
		chk(8'(runs - r0), 8'h01, "run pulses");
		fault_pin_in <= 2'h2;
		cyc(4);
		chk({7'h00, alert_oe}, 8'h01, "alert");
		wr(CMD_CHAN_OPT, 8'h0F, 1'b1);
		cyc(4);
		chk({7'h00, alert_oe}, 8'h00, "alert");
		$display("test channel options done");
		give_verdict();
	end
endmodule // pwl_lock_test
